// [rtl/mrs_pkg.sv]
// Constants, field positions and state encoding for the recorder request handler.
// Assumes one 40 MHz clock and a byte stream already framed by the serial receiver.
package mrs_pkg;
   localparam logic [7:0]  FC_READ_COILS    = 8'h01;
   localparam logic [7:0]  FC_READ_INPUTS   = 8'h02;
   localparam logic [7:0]  FC_READ_HOLDING  = 8'h03;
   localparam logic [7:0]  FC_READ_INPUTREG = 8'h04;
   localparam logic [7:0]  FC_WRITE_MULTI   = 8'h10;
   localparam logic [7:0]  FC_REPORT_ID     = 8'h11;
   localparam logic [7:0]  EXC_FLAG         = 8'h80;
   localparam logic [7:0]  EXC_NONE         = 8'h00;
   localparam logic [7:0]  EXC_ILLEGAL_FUNC = 8'h01;
   localparam logic [7:0]  EXC_ILLEGAL_ADDR = 8'h02;
   localparam logic [7:0]  EXC_ILLEGAL_DATA = 8'h03;
   localparam logic [7:0]  BROADCAST_ADDR   = 8'h00;
   localparam logic [15:0] TEXT_ADDR        = 16'h0004;
   localparam int          TEXT_MAX_BYTES   = 32;
   localparam logic [15:0] COMMS_BASE       = 16'h1880;
   localparam int          COMMS_SLOTS      = 32;
   localparam int          REGS_PER_FLOAT   = 2;
   localparam int          COMMS_WORDS      = COMMS_SLOTS * REGS_PER_FLOAT;
   localparam logic [15:0] ALARM_BASE       = 16'h1980;
   localparam int          ALARM_BITS       = 6;
   localparam logic [15:0] MAX_READ_REGS    = 16'h007D;
   localparam logic [15:0] MAX_READ_BITS    = 16'h07D0;
   localparam int          DESC_BYTES       = 16;
   localparam logic [7:0]  RUN_INDICATOR    = 8'hFF;
   localparam logic [7:0]  ID_BLOCK_COUNT   = 8'h05;
   localparam logic [39:0] ID_BLOCK_TYPES   = 40'h00_02_03_06_09;
   localparam logic [7:0]  ID_REPLY_LEN     = 8'h1D;
   localparam logic [7:0]  ID_BYTE_COUNT    = 8'h1A;
   localparam int          POS_ADDR         = 0;
   localparam int          POS_FC           = 1;
   localparam int          POS_START_HI     = 2;
   localparam int          POS_START_LO     = 3;
   localparam int          POS_QTY_HI       = 4;
   localparam int          POS_QTY_LO       = 5;
   localparam int          POS_BYTE_COUNT   = 6;
   localparam int          POS_DATA         = 7;
   localparam int          POS_ID_SLAVE     = 3;
   localparam int          POS_ID_RUN       = 4;
   localparam int          POS_ID_DESC      = 5;
   localparam int          POS_ID_BLOCKS    = 23;
   localparam int          REPLY_HDR        = 3;
   localparam logic [7:0]  WRITE_REPLY_LEN  = 8'h06;
   localparam logic [7:0]  EXC_REPLY_LEN    = 8'h03;
   localparam logic [7:0]  READ_REQ_LEN     = 8'h08;
   localparam logic [7:0]  ID_REQ_LEN       = 8'h04;
   localparam logic [7:0]  MIN_FRAME        = 8'h04;
   localparam logic [8:0]  WRITE_OVERHEAD   = 9'h009;
   localparam logic [15:0] CRC_INIT         = 16'hFFFF;
   localparam logic [15:0] CRC_POLY         = 16'hA001;

   typedef enum logic [2:0] {
      PH_IDLE   = 3'b000,
      PH_EXEC   = 3'b001,
      PH_REPLY  = 3'b010,
      PH_CRC_LO = 3'b011,
      PH_CRC_HI = 3'b100
   } mrs_phase_e;
endpackage : mrs_pkg

// [rtl/mrs_crc_if.sv]
// Carrier between the request handler and its CRC-16 engines.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface mrs_crc_if;
   logic        clear;
   logic        feed;
   logic [7:0]  data;
   logic [15:0] crc;
   logic [15:0] crcNext;
   modport user   (output clear, output feed, output data, input crc, input crcNext);
   modport engine (input clear, input feed, input data, output crc, output crcNext);
endinterface : mrs_crc_if

// [rtl/mrs_crc16.sv]
// Byte-wide CRC-16 engine, reflected polynomial, one byte per clock.
// Assumes clear and feed come from logic on the same clock.
`timescale 1ns/1ps
module mrs_crc16 (
   input wire logic clk,
   input wire logic reset,
   mrs_crc_if.engine port
);
   typedef struct packed {
      logic [15:0] crc;
   } mrs_crc_s;

   mrs_crc_s s;
   mrs_crc_s next_s;

   function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ mrs_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crcByte

   // Clear restarts the sum; a byte fed in the same cycle is the first of the new sum
   always_comb begin
      next_s = s;
      next_s.crc = port.clear ? mrs_pkg::CRC_INIT : s.crc;
      if (port.feed) begin
         next_s.crc = crcByte(next_s.crc, port.data);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s.crc <= mrs_pkg::CRC_INIT;
      end else begin
         s <= next_s;
      end
   end

   assign port.crc     = s.crc;
   assign port.crcNext = next_s.crc;
endmodule : mrs_crc16

// [rtl/mrs_slave.sv]
// Request handler for the recorder's serial slave: parses framed requests, serves reads,
// takes text and remote value writes, answers identification and exceptions.
// Assumes a receiver on the same clock that delivers bytes and marks each frame's end.
`timescale 1ns/1ps
module mrs_slave #(
   parameter int                              PENS        = 96,
   parameter int                              FRAME_MAX   = 137,
   parameter logic [7:0]                      SLAVE_ID    = 8'h5A, // Arbitrary identity value
   parameter logic [mrs_pkg::DESC_BYTES*8-1:0] DEVICE_DESC = {"REC 00.AA", 56'h0}
) (
   input  wire logic                                      clk,
   input  wire logic                                      reset,
   input  wire logic [7:0]                                slaveAddress,
   input  wire logic                                      rxValid,
   input  wire logic [7:0]                                rxData,
   input  wire logic                                      rxEnd,
   output logic                                           txValid,
   input  wire logic                                      txReady,
   output logic [7:0]                                     txData,
   output logic [15:0]                                    lookAddr,
   input  wire logic [7:0]                                lookBits,
   input  wire logic [31:0]                               lookFloat,
   input  wire logic [PENS-1:0][mrs_pkg::ALARM_BITS-1:0] penAlarm,
   output logic [mrs_pkg::COMMS_SLOTS-1:0][31:0]         remoteValue,
   output logic                                           textStrobe,
   output logic [mrs_pkg::TEXT_MAX_BYTES-1:0][7:0]       textMessage,
   output logic [5:0]                                     textLength
);
   initial begin
      if (PENS < 1 || PENS > 256) $error("PENS out of range");
      if (FRAME_MAX < 137 || FRAME_MAX > 255) $error("FRAME_MAX out of range");
   end

   typedef struct packed {
      mrs_pkg::mrs_phase_e                          st;
      logic [FRAME_MAX-1:0][7:0]                    buffer;
      logic [7:0]                                   len;
      logic                                         over;
      logic [mrs_pkg::COMMS_WORDS-1:0][15:0]        comms;
      logic [mrs_pkg::TEXT_MAX_BYTES-1:0][7:0]      text;
      logic [5:0]                                   textLen;
      logic                                         textStrobe;
      logic [7:0]                                   excCode;
      logic [7:0]                                   respLen;
      logic [7:0]                                   respIdx;
      logic [7:0]                                   cur;
      logic [7:0]                                   crcHi;
   } mrs_state_s;

   mrs_state_s s;
   mrs_state_s next_s;
   mrs_crc_if  rxCrc ();
   mrs_crc_if  txCrc ();

   mrs_crc16 rxCrcEngine (.clk(clk), .reset(reset), .port(rxCrc));
   mrs_crc16 txCrcEngine (.clk(clk), .reset(reset), .port(txCrc));

   logic [7:0]  fc;
   logic [15:0] start;
   logic [15:0] qty;
   logic [7:0]  lookIdx;
   logic [7:0]  dataIdx;
   logic        accept;
   logic        frameOk;

   assign fc      = s.buffer[mrs_pkg::POS_FC];
   assign start   = {s.buffer[mrs_pkg::POS_START_HI], s.buffer[mrs_pkg::POS_START_LO]};
   assign qty     = {s.buffer[mrs_pkg::POS_QTY_HI], s.buffer[mrs_pkg::POS_QTY_LO]};
   assign accept  = txValid && txReady;
   assign lookIdx = (s.st == mrs_pkg::PH_EXEC) ? 8'h00 : 8'(s.respIdx + 8'h01);
   assign dataIdx = 8'(lookIdx - 8'(mrs_pkg::REPLY_HDR));
   assign lookAddr = (fc == mrs_pkg::FC_READ_COILS || fc == mrs_pkg::FC_READ_INPUTS) ?
                     16'(start + {5'h00, dataIdx, 3'b000}) : 16'(start + {9'h000, dataIdx[7:1]});
   // Bad checksum leaves a nonzero residue over the whole frame; such frames are dropped
   assign frameOk = (s.len >= mrs_pkg::MIN_FRAME) && !s.over && (rxCrc.crc == 16'h0000) &&
                    (s.buffer[mrs_pkg::POS_ADDR] == slaveAddress ||
                     s.buffer[mrs_pkg::POS_ADDR] == mrs_pkg::BROADCAST_ADDR);

   localparam int POS_BC_REPLY = 2;

   function automatic logic [7:0] replyByte(input logic [7:0] idx);
      logic [15:0] word;
      logic [7:0]  k;
      logic [15:0] pen;
      logic [15:0] left;
      logic [7:0]  b;
      word = 16'h0000;
      pen  = 16'(lookAddr - mrs_pkg::ALARM_BASE);
      left = 16'(qty - {5'h00, dataIdx, 3'b000});
      b    = 8'h00;
      if (idx == 8'(mrs_pkg::POS_ADDR)) begin
         b = s.buffer[mrs_pkg::POS_ADDR];
      end else if (idx == 8'(mrs_pkg::POS_FC)) begin
         b = (s.excCode != mrs_pkg::EXC_NONE) ? (fc | mrs_pkg::EXC_FLAG) : fc;
      end else if (s.excCode != mrs_pkg::EXC_NONE) begin
         b = s.excCode;
      end else begin
         case (fc)
            mrs_pkg::FC_READ_COILS, mrs_pkg::FC_READ_INPUTS: begin
               if (idx == 8'(POS_BC_REPLY)) b = 8'(16'(qty + 16'h0007) >> 3);
               else if (left < 16'h0008) b = lookBits & 8'(~(8'hFF << left[2:0]));
               else b = lookBits;
            end
            mrs_pkg::FC_READ_HOLDING, mrs_pkg::FC_READ_INPUTREG: begin
               if (lookAddr >= mrs_pkg::ALARM_BASE && pen < 16'(PENS)) begin
                  word = 16'(penAlarm[pen[7:0]]);
               end else begin
                  word = lookAddr[0] ? lookFloat[15:0] : lookFloat[31:16];
               end
               if (idx == 8'(POS_BC_REPLY)) b = 8'({qty[6:0], 1'b0});
               else b = dataIdx[0] ? word[7:0] : word[15:8];
            end
            mrs_pkg::FC_WRITE_MULTI: begin
               b = s.buffer[idx];
            end
            mrs_pkg::FC_REPORT_ID: begin
               if (idx == 8'(POS_BC_REPLY)) b = mrs_pkg::ID_BYTE_COUNT;
               else if (idx == 8'(mrs_pkg::POS_ID_SLAVE)) b = SLAVE_ID;
               else if (idx == 8'(mrs_pkg::POS_ID_RUN)) b = mrs_pkg::RUN_INDICATOR;
               else if (idx < 8'(mrs_pkg::POS_ID_DESC + mrs_pkg::DESC_BYTES)) begin
                  k = 8'(idx - 8'(mrs_pkg::POS_ID_DESC));
                  b = DEVICE_DESC[{k[3:0] ^ 4'(mrs_pkg::DESC_BYTES - 1), 3'b000} +: 8];
               end else if (idx == 8'(mrs_pkg::POS_ID_BLOCKS)) b = mrs_pkg::ID_BLOCK_COUNT;
               else if (idx > 8'(mrs_pkg::POS_ID_BLOCKS)) begin
                  k = 8'(mrs_pkg::ID_BLOCK_COUNT + 8'(mrs_pkg::POS_ID_BLOCKS) - idx);
                  b = mrs_pkg::ID_BLOCK_TYPES[{k[2:0], 3'b000} +: 8];
               end
            end
            default: b = 8'h00;
         endcase
      end
      return b;
   endfunction : replyByte

   always_comb begin
      logic [16:0] reach;
      logic [7:0]  bc;
      int          off;
      reach = 17'(start) + 17'(qty);
      bc    = s.buffer[mrs_pkg::POS_BYTE_COUNT];
      off   = int'(16'(start - mrs_pkg::COMMS_BASE));
      next_s = s;
      next_s.textStrobe = 1'b0;
      case (s.st)
         mrs_pkg::PH_IDLE: begin
            if (rxValid) begin
               if (s.len == 8'(FRAME_MAX)) next_s.over = 1'b1;
               else begin
                  next_s.buffer[s.len] = rxData;
                  next_s.len = 8'(s.len + 8'h01);
               end
            end
            if (rxEnd) begin
               next_s.over = 1'b0;
               if (frameOk) next_s.st = mrs_pkg::PH_EXEC;
               else next_s.len = 8'h00;
            end
         end
         mrs_pkg::PH_EXEC: begin
            next_s.excCode = mrs_pkg::EXC_NONE;
            next_s.respIdx = 8'h00;
            next_s.len     = 8'h00;
            case (fc)
               mrs_pkg::FC_READ_COILS, mrs_pkg::FC_READ_INPUTS: begin
                  if (s.len != mrs_pkg::READ_REQ_LEN || qty == 16'h0000 ||
                      qty > mrs_pkg::MAX_READ_BITS) next_s.excCode = mrs_pkg::EXC_ILLEGAL_DATA;
                  next_s.respLen = 8'(8'(mrs_pkg::REPLY_HDR) + 8'(16'(qty + 16'h0007) >> 3));
               end
               mrs_pkg::FC_READ_HOLDING, mrs_pkg::FC_READ_INPUTREG: begin
                  if (s.len != mrs_pkg::READ_REQ_LEN || qty == 16'h0000 ||
                      qty > mrs_pkg::MAX_READ_REGS) next_s.excCode = mrs_pkg::EXC_ILLEGAL_DATA;
                  next_s.respLen = 8'(8'(mrs_pkg::REPLY_HDR) + {qty[6:0], 1'b0});
               end
               mrs_pkg::FC_WRITE_MULTI: begin
                  next_s.respLen = mrs_pkg::WRITE_REPLY_LEN;
                  if ({1'b0, s.len} != 9'(mrs_pkg::WRITE_OVERHEAD + 9'(bc)) || bc == 8'h00) begin
                     next_s.excCode = mrs_pkg::EXC_ILLEGAL_DATA;
                  end else if (start == mrs_pkg::TEXT_ADDR) begin
                     if (bc > 8'(mrs_pkg::TEXT_MAX_BYTES) ||
                         qty != 16'({8'h00, bc} + 16'h0001) >> 1) begin
                        next_s.excCode = mrs_pkg::EXC_ILLEGAL_DATA;
                     end else begin
                        for (int i = 0; i < mrs_pkg::TEXT_MAX_BYTES; i++) begin
                           next_s.text[i] = (8'(i) < bc) ? s.buffer[mrs_pkg::POS_DATA + i] : 8'h00;
                        end
                        next_s.textLen    = 6'(bc);
                        next_s.textStrobe = 1'b1;
                     end
                  end else if (start >= mrs_pkg::COMMS_BASE && qty != 16'h0000 &&
                               reach <= 17'(mrs_pkg::COMMS_BASE) + 17'(mrs_pkg::COMMS_WORDS) &&
                               {qty[14:0], 1'b0} == {8'h00, bc}) begin
                     for (int w = 0; w < mrs_pkg::COMMS_WORDS; w++) begin
                        if (w >= off && w < off + int'(qty)) begin
                           next_s.comms[w] = {s.buffer[mrs_pkg::POS_DATA + 2 * (w - off)],
                                              s.buffer[mrs_pkg::POS_DATA + 2 * (w - off) + 1]};
                        end
                     end
                  end else begin
                     next_s.excCode = mrs_pkg::EXC_ILLEGAL_ADDR;
                  end
               end
               mrs_pkg::FC_REPORT_ID: begin
                  if (s.len != mrs_pkg::ID_REQ_LEN) next_s.excCode = mrs_pkg::EXC_ILLEGAL_DATA;
                  next_s.respLen = mrs_pkg::ID_REPLY_LEN;
               end
               default: next_s.excCode = mrs_pkg::EXC_ILLEGAL_FUNC;
            endcase
            if (next_s.excCode != mrs_pkg::EXC_NONE) next_s.respLen = mrs_pkg::EXC_REPLY_LEN;
            next_s.cur = replyByte(8'h00);
            // Broadcast writes take effect but are never answered
            next_s.st = (s.buffer[mrs_pkg::POS_ADDR] == mrs_pkg::BROADCAST_ADDR) ?
                        mrs_pkg::PH_IDLE : mrs_pkg::PH_REPLY;
         end
         mrs_pkg::PH_REPLY: begin
            if (txReady) begin
               if (s.respIdx == 8'(s.respLen - 8'h01)) begin
                  next_s.cur   = txCrc.crcNext[7:0];
                  next_s.crcHi = txCrc.crcNext[15:8];
                  next_s.st    = mrs_pkg::PH_CRC_LO;
               end else begin
                  next_s.cur     = replyByte(lookIdx);
                  next_s.respIdx = lookIdx;
               end
            end
         end
         mrs_pkg::PH_CRC_LO: begin
            if (txReady) begin
               next_s.cur = s.crcHi;
               next_s.st  = mrs_pkg::PH_CRC_HI;
            end
         end
         mrs_pkg::PH_CRC_HI: begin
            if (txReady) next_s.st = mrs_pkg::PH_IDLE;
         end
         default: next_s.st = mrs_pkg::PH_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rxCrc.clear = (s.st == mrs_pkg::PH_IDLE) && rxEnd;
   assign rxCrc.feed  = (s.st == mrs_pkg::PH_IDLE) && rxValid && !rxEnd;
   assign rxCrc.data  = rxData;
   assign txCrc.clear = (s.st == mrs_pkg::PH_EXEC);
   assign txCrc.feed  = (s.st == mrs_pkg::PH_REPLY) && accept;
   assign txCrc.data  = s.cur;
   assign txValid     = (s.st == mrs_pkg::PH_REPLY) || (s.st == mrs_pkg::PH_CRC_LO) ||
                        (s.st == mrs_pkg::PH_CRC_HI);
   assign txData      = s.cur;
   assign textStrobe  = s.textStrobe;
   assign textMessage = s.text;
   assign textLength  = s.textLen;
   for (genvar k = 0; k < mrs_pkg::COMMS_SLOTS; k++) begin : g_slot
      assign remoteValue[k] = {s.comms[2 * k], s.comms[2 * k + 1]};
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_bad_crc_drop: assert property ((s.st == mrs_pkg::PH_IDLE && rxEnd && rxCrc.crc != 16'h0000)
      |=> s.st == mrs_pkg::PH_IDLE) else $error("bad CRC frame executed");
   a_crc_tail_order: assert property ((s.st == mrs_pkg::PH_CRC_LO && txReady)
      |=> s.st == mrs_pkg::PH_CRC_HI && txData == $past(s.crcHi)) else $error("CRC order");
   a_illegal_func: assert property ((s.st == mrs_pkg::PH_EXEC && !(fc inside {8'h01, 8'h02,
      8'h03, 8'h04, 8'h10, 8'h11})) |=> s.excCode == mrs_pkg::EXC_ILLEGAL_FUNC
      && s.respLen == mrs_pkg::EXC_REPLY_LEN) else $error("no illegal-function reply");
   a_text_strobe: assert property (textStrobe |-> $past(s.st) == mrs_pkg::PH_EXEC
      && $past(fc) == mrs_pkg::FC_WRITE_MULTI && $past(start) == mrs_pkg::TEXT_ADDR)
      else $error("text strobe without text write");
   a_text_length: assert property (textStrobe |-> textLength != 6'h00
      && textLength <= 6'(mrs_pkg::TEXT_MAX_BYTES)) else $error("text length bad");
   a_write_echo: assert property ((s.st == mrs_pkg::PH_REPLY && fc == mrs_pkg::FC_WRITE_MULTI
      && s.excCode == mrs_pkg::EXC_NONE) |-> txData == s.buffer[s.respIdx])
      else $error("write reply not an echo");
   a_comms_store: assert property ((s.st == mrs_pkg::PH_EXEC && fc == mrs_pkg::FC_WRITE_MULTI
      && start == mrs_pkg::COMMS_BASE) ##1 s.excCode == mrs_pkg::EXC_NONE |->
      remoteValue[0][31:16] == {$past(s.buffer[7]), $past(s.buffer[8])})
      else $error("remote value not stored");
   a_id_desc: assert property ((s.st == mrs_pkg::PH_REPLY && fc == mrs_pkg::FC_REPORT_ID
      && s.excCode == mrs_pkg::EXC_NONE && s.respIdx == 8'h14)
      |-> txData == DEVICE_DESC[7:0]) else $error("description not 16 bytes");
   a_id_blocks: assert property ((s.st == mrs_pkg::PH_REPLY && fc == mrs_pkg::FC_REPORT_ID
      && s.excCode == mrs_pkg::EXC_NONE && s.respIdx == 8'h17 && txReady)
      |-> txData == 8'h05 ##1 txData == 8'h00 ##1 (!$past(txReady) || txData == 8'h02))
      else $error("block records wrong");

   c_text_write: cover property (textStrobe);
   c_id_reply: cover property (s.st == mrs_pkg::PH_REPLY && fc == mrs_pkg::FC_REPORT_ID);
   c_exception: cover property (s.st == mrs_pkg::PH_CRC_HI && s.excCode != mrs_pkg::EXC_NONE);
   c_float_read: cover property (s.st == mrs_pkg::PH_REPLY && fc == mrs_pkg::FC_READ_HOLDING);
endmodule : mrs_slave

// [verif/mrs_master_model.sv]
// Serial master model: delivers request frames byte by byte with CRC appended.
// Assumes the handler's receive port and one clock.
`timescale 1ns/1ps
module mrs_master_model (
   input  wire logic       clk,
   output logic            rxValid = 1'b0,
   output logic [7:0]      rxData  = 8'h00,
   output logic            rxEnd   = 1'b0
);
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++) begin
            c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
         end
      end
      return c;
   endfunction : crc16
   // Requests carry the caller's bytes as given; bad flips the low bit of the CRC
   task automatic send(input logic [7:0] q[$], input logic bad);
      logic [15:0] c;
      c = crc16(q) ^ {15'h0000, bad};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      foreach (q[i]) begin
         @(posedge clk);
         rxValid <= 1'b1;
         rxData  <= q[i];
      end
      @(posedge clk);
      rxValid <= 1'b0;
      rxData  <= ~rxData;
      rxEnd   <= 1'b1;
      @(posedge clk);
      rxEnd <= 1'b0;
   endtask : send
endmodule : mrs_master_model

// [verif/mrs_slave_tb_top.sv]
// Bench for the request handler: master model drives frames, replies checked from a queue.
// Assumes the handler package and interface are compiled first.
`timescale 1ns/1ps
module mrs_slave_tb_top;
   localparam logic [7:0]   ID   = 8'h3C; // Arbitrary identity value
   localparam logic [127:0] DESC = {"RT 12.AB", 64'h0};
   logic                  clk, reset, rxValid, rxEnd, txValid, txReady, textStrobe;
   logic [7:0]            rxData, txData, lookBits, slaveAddress, bitBase;
   logic [15:0]           lookAddr;
   logic [31:0]           lookFloat, v, floatBase;
   logic [3:0][5:0]       penAlarm;
   logic [31:0][31:0]     remoteValue;
   logic [31:0][7:0]      textMessage;
   logic [5:0]            textLength;
   logic [7:0]            exp[$], q[$], r[$];
   int                    n_errors, checked, cycles, strobes, seed;
   mrs_slave #(.PENS(4), .SLAVE_ID(ID), .DEVICE_DESC(DESC)) DUT (.clk(clk), .reset(reset),
      .slaveAddress(slaveAddress), .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd),
      .txValid(txValid), .txReady(txReady), .txData(txData), .lookAddr(lookAddr),
      .lookBits(lookBits), .lookFloat(lookFloat), .penAlarm(penAlarm),
      .remoteValue(remoteValue), .textStrobe(textStrobe), .textMessage(textMessage),
      .textLength(textLength));
   mrs_master_model u_master (.clk(clk), .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd));
   // Lookup answers depend on the address asked for, so a wrong address shows in the reply
   assign lookBits  = bitBase ^ lookAddr[7:0];
   assign lookFloat = floatBase ^ {16'h0000, lookAddr[15:1], 1'b0};
   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : cmp
   task automatic stop_test;
      if (n_errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   // Queues the expected reply with its CRC, sends the request held in q, waits for the end
   task automatic xfer(input logic [7:0] e[$], input logic bad);
      logic [15:0] c;
      c = u_master.crc16(e);
      exp = e;
      if (e.size() > 0) begin
         exp.push_back(c[7:0]);
         exp.push_back(c[15:8]);
      end
      u_master.send(q, bad);
      repeat (3) @(posedge clk);
      for (int i = 0; i < 500 && (exp.size() > 0 || txValid !== 1'b0); i++) @(posedge clk);
      cmp("pending bytes", 32'h0, exp.size());
   endtask : xfer
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      txReady <= 1'(($random(seed) & 3) != 0);
      if (textStrobe === 1'b1) strobes++;
      if (cycles == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   always @(negedge clk) begin
      if (txValid === 1'b1 && txReady === 1'b1) begin
         if (exp.size() == 0) cmp("extra reply byte", 32'h1, 32'h0);
         else cmp("reply byte", exp.pop_front(), txData);
      end
   end
   initial begin
      seed = 29;
      reset = 1'b1;
      slaveAddress = 8'h02;
      txReady = 1'b0;
      bitBase = 8'h00;
      floatBase = 32'h0;
      penAlarm = '0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      bitBase <= 8'($random(seed));
      floatBase <= $random(seed);
      penAlarm <= 24'($random(seed));
      v = $random(seed);
      q = '{8'h02, 8'h10, 8'h00, 8'h04, 8'h00, 8'h03, 8'h05, 8'h53, 8'h74, 8'h61, 8'h72, 8'h74};
      xfer('{8'h02, 8'h10, 8'h00, 8'h04, 8'h00, 8'h03}, 1'b0);
      cmp("text length", 32'h5, textLength);
      cmp("text first", 32'h53, textMessage[0]);
      cmp("text pad", 32'h0, textMessage[5]);
      xfer('{}, 1'b1);
      q[5] = 8'h02;
      xfer('{8'h02, 8'h90, 8'h03}, 1'b0);
      cmp("text strobes", 32'h1, strobes);
      q = '{8'h02, 8'h10, 8'h00, 8'h04, 8'h00, 8'h10, 8'h20};
      for (int i = 0; i < 32; i++) q.push_back(8'h41 + 8'(i));
      xfer('{8'h02, 8'h10, 8'h00, 8'h04, 8'h00, 8'h10}, 1'b0);
      cmp("text last", 32'h60, textMessage[31]);
      q = '{8'h02, 8'h10, 8'h18, 8'hBE, 8'h00, 8'h02, 8'h04, v[31:24], v[23:16], v[15:8], v[7:0]};
      xfer('{8'h02, 8'h10, 8'h18, 8'hBE, 8'h00, 8'h02}, 1'b0);
      cmp("slot last", v, remoteValue[31]);
      cmp("slot first", 32'h0, remoteValue[0]);
      v = ~v;
      q = '{8'h02, 8'h10, 8'h18, 8'h80, 8'h00, 8'h02, 8'h04, v[31:24], v[23:16], v[15:8], v[7:0]};
      xfer('{8'h02, 8'h10, 8'h18, 8'h80, 8'h00, 8'h02}, 1'b0);
      cmp("slot first written", v, remoteValue[0]);
      cmp("slot last kept", ~v, remoteValue[31]);
      q = '{8'h02, 8'h03, 8'h19, 8'h83, 8'h00, 8'h01};
      xfer('{8'h02, 8'h03, 8'h02, 8'h00, {2'b00, penAlarm[3]}}, 1'b0);
      q = '{8'h02, 8'h04, 8'h18, 8'hC0, 8'h00, 8'h02};
      r = '{8'h02, 8'h04, 8'h04, floatBase[31:24], floatBase[23:16], floatBase[15:8] ^ 8'h18};
      r.push_back(floatBase[7:0] ^ 8'hC0);
      xfer(r, 1'b0);
      for (int f = 1; f < 3; f++) begin
         q = '{8'h02, 8'(f), 8'h00, 8'h30, 8'h00, 8'h08};
         xfer('{8'h02, 8'(f), 8'h01, bitBase ^ 8'h30}, 1'b0);
      end
      for (int f = 5; f < 7; f++) begin
         q = '{8'h02, 8'(f), 8'h00, 8'h00, 8'h00, 8'h01};
         xfer('{8'h02, 8'h80 | 8'(f), 8'h01}, 1'b0);
      end
      q = '{8'h02, 8'h11};
      r = '{8'h02, 8'h11, 8'h1A, ID, 8'hFF};
      for (int i = 0; i < 16; i++) r.push_back(DESC[127-8*i -: 8]);
      r = {r, 8'h00, 8'h00, 8'h05, 8'h00, 8'h02, 8'h03, 8'h06, 8'h09};
      xfer(r, 1'b0);
      stop_test();
   end
endmodule : mrs_slave_tb_top
